// ### shared/cpsreg_regs.vh
`ifndef CPSREG_REGS_VH
`define CPSREG_REGS_VH

// Register addresses within a page
`define CPS_A_CMD 4'h0
`define CPS_A_RING_START 4'h1
`define CPS_A_RING_STOP 4'h2
`define CPS_A_RNPP 4'h3
`define CPS_A_TX_START 4'h4
`define CPS_A_LNPP 4'h5
`define CPS_A_ACNT_HI 4'h6
`define CPS_A_ACNT_LO 4'h7
`define CPS_A_RCNT_LO 4'ha
`define CPS_A_RCNT_HI 4'hb
`define CPS_A_RX_CFG 4'hc
`define CPS_A_TX_CFG 4'hd
`define CPS_A_DATA_CFG 4'he
`define CPS_A_INT_MASK 4'hf

// Page codes
`define CPS_PAGE0 2'h0
`define CPS_PAGE1 2'h1
`define CPS_PAGE2 2'h2
`define CPS_PAGE3 2'h3

// Command register bit positions
`define CPS_B_HALT 0
`define CPS_B_RUN 1
`define CPS_B_GO 2
`define CPS_B_RDMA_LO 3
`define CPS_B_RDMA_HI 5
`define CPS_B_PAGE_LO 6
`define CPS_B_PAGE_HI 7

// Remote DMA codes
`define CPS_RDMA_NONE 3'h0
`define CPS_RDMA_READ 3'h1
`define CPS_RDMA_WRITE 3'h2
`define CPS_RDMA_SEND 3'h3
`define CPS_RDMA_ABORT 3'h4

// Reset values
`define CPS_RST_PAGE 2'h0
`define CPS_RST_RDMA 3'h4
`define CPS_RST_HALT 1'h1
`define CPS_RST_RUN 1'h0
`define CPS_RST_STATUS 1'h1

`endif

// ### design/cpsreg_sync3.v
`timescale 1ns/1ns
`default_nettype none
module cpsreg_sync3 (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Asynchronous level in, filtered level out
   input wire d,
   output reg q
);

reg ff1_r;
reg ff2_r;
reg ff3_r;

// Three stages; q follows only once stages two and three agree
always @(posedge clk) begin
   if (rst) begin
      ff1_r <= 1'h0;
      ff2_r <= 1'h0;
      ff3_r <= 1'h0;
      q <= 1'h0;
   end else begin
      ff1_r <= d;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (ff2_r == ff3_r) begin
         q <= ff3_r;
      end
   end
end

endmodule
`default_nettype wire

// ### design/cpsreg_page_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsreg_regs.vh"
module cpsreg_page_decode (
   // Access target
   input wire [1:0] page,
   input wire [3:0] addr,
   // Read sources
   input wire [7:0] cmd_value,
   input wire [7:0] ext_rd_data,
   input wire [7:0] ring_start_page,
   input wire [7:0] ring_stop_page,
   input wire [7:0] tx_start_page,
   input wire [7:0] rx_config,
   input wire [7:0] tx_config,
   input wire [7:0] data_config,
   input wire [7:0] int_mask,
   // Decode results
   output reg [7:0] rd_data,
   output reg rd_ext,
   output reg wr_ext
);

// Page and address select the register reached
always @* begin
   rd_data = 8'h00;
   rd_ext = 1'b0;
   wr_ext = 1'b0;
   if (addr == `CPS_A_CMD) begin
      rd_data = cmd_value;
   end else begin
      case (page)
         `CPS_PAGE0, `CPS_PAGE1: begin
            rd_data = ext_rd_data;
            rd_ext = 1'b1;
            wr_ext = 1'b1;
         end
         `CPS_PAGE2: begin
            // Diagnostic read-back copies; writes to 04 and 08-0F dropped
            case (addr)
               `CPS_A_RING_START: begin
                  rd_data = ring_start_page;
                  wr_ext = 1'b1;
               end
               `CPS_A_RING_STOP: begin
                  rd_data = ring_stop_page;
                  wr_ext = 1'b1;
               end
               `CPS_A_TX_START: rd_data = tx_start_page;
               `CPS_A_RNPP, `CPS_A_LNPP, `CPS_A_ACNT_HI, `CPS_A_ACNT_LO: begin
                  rd_data = ext_rd_data;
                  rd_ext = 1'b1;
                  wr_ext = 1'b1;
               end
               `CPS_A_RX_CFG: rd_data = rx_config;
               `CPS_A_TX_CFG: rd_data = tx_config;
               `CPS_A_DATA_CFG: rd_data = data_config;
               `CPS_A_INT_MASK: rd_data = int_mask;
               default: rd_data = 8'h00;
            endcase
         end
         // Reserved page: reads zero, writes go nowhere
         default: rd_data = 8'h00;
      endcase
   end
end

endmodule
`default_nettype wire

// ### design/cpsreg_top.v
`timescale 1ns/1ns
`default_nettype none
`include "cpsreg_regs.vh"
module cpsreg_top (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Host register pins
   input wire [3:0] reg_addr_lines,
   input wire rd_strobe,
   input wire wr_strobe,
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output reg data_oe,
   // Remote DMA acknowledge pins and port request
   input wire read_ack_in,
   input wire write_ack_in,
   output reg port_request_out,
   // Register bank outside this block
   output wire ext_wr_pulse,
   output wire ext_rd_pulse,
   output reg [1:0] ext_page,
   output reg [3:0] ext_addr,
   output reg [7:0] ext_wr_data,
   input wire [7:0] ext_rd_data,
   // Read-back copies for page 2
   input wire [7:0] ring_start_page,
   input wire [7:0] ring_stop_page,
   input wire [7:0] tx_start_page,
   input wire [7:0] rx_config,
   input wire [7:0] tx_config,
   input wire [7:0] data_config,
   input wire [7:0] int_mask,
   // Controller status and control
   input wire rx_busy,
   input wire tx_busy,
   input wire fault_stop,
   output reg controller_online,
   output reg int_status_rst,
   // Transmit engine
   output reg tx_go_pulse,
   input wire tx_done,
   input wire tx_abort,
   // Remote DMA engine
   output reg rdma_start_pulse,
   output reg rdma_abort_pulse,
   output reg rdma_done_now,
   output wire [2:0] rdma_cmd,
   input wire rdma_finished,
   input wire rdma_count_zero,
   input wire rdma_prq_req
);

localparam ST_STOPPED = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_DRAIN = 2'h2;

// Synchronised pin levels
wire rd_s;
wire wr_s;
wire read_ack_in_s;
wire write_ack_in_s;

// Access pipeline
reg rd_d_r;
reg wr_d_r;
reg read_ack_in_d_r;
reg write_ack_in_d_r;
reg acc_rd_r;
reg acc_wr_r;
reg [3:0] addr_r;
reg [7:0] wdata_r;

// Command register fields
reg [1:0] page_r;
reg [2:0] rdma_cmd_r;
reg go_r;
reg run_r;
reg halt_r;

// Controller and remote DMA state
reg [1:0] run_state_r;
reg [1:0] run_state_nxt;
reg rdma_active_r;
reg reload_r;
reg prq_hold_r;

wire [7:0] cmd_value;
wire [7:0] dec_rd_data;
wire dec_rd_ext;
wire dec_wr_ext;
wire cr_wr;
wire [2:0] wr_rdma;
wire busy;
wire ack_rise;
wire enter_stop;
wire start_cmd;
wire prq_set;

cpsreg_sync3 u_sync_rd (
   .clk(clk),
   .rst(rst),
   .d(rd_strobe),
   .q(rd_s)
);

cpsreg_sync3 u_sync_wr (
   .clk(clk),
   .rst(rst),
   .d(wr_strobe),
   .q(wr_s)
);

cpsreg_sync3 u_sync_read_ack_in (
   .clk(clk),
   .rst(rst),
   .d(read_ack_in),
   .q(read_ack_in_s)
);

cpsreg_sync3 u_sync_write_ack_in (
   .clk(clk),
   .rst(rst),
   .d(write_ack_in),
   .q(write_ack_in_s)
);

// Command register image as read back
assign cmd_value = {page_r, rdma_cmd_r, go_r, run_r, halt_r};
assign rdma_cmd = rdma_cmd_r;

cpsreg_page_decode u_decode (
   .page(page_r),
   .addr(addr_r),
   .cmd_value(cmd_value),
   .ext_rd_data(ext_rd_data),
   .ring_start_page(ring_start_page),
   .ring_stop_page(ring_stop_page),
   .tx_start_page(tx_start_page),
   .rx_config(rx_config),
   .tx_config(tx_config),
   .data_config(data_config),
   .int_mask(int_mask),
   .rd_data(dec_rd_data),
   .rd_ext(dec_rd_ext),
   .wr_ext(dec_wr_ext)
);

// Command register answers at address 0 of every page
assign cr_wr = acc_wr_r & (addr_r == `CPS_A_CMD);
assign wr_rdma = wdata_r[`CPS_B_RDMA_HI:`CPS_B_RDMA_LO];
assign ext_wr_pulse = acc_wr_r & dec_wr_ext;
assign ext_rd_pulse = acc_rd_r & dec_rd_ext;
assign busy = rx_busy | tx_busy;
assign ack_rise = (read_ack_in_s & ~read_ack_in_d_r) | (write_ack_in_s & ~write_ack_in_d_r);
assign enter_stop = (run_state_r != ST_STOPPED) & (run_state_nxt == ST_STOPPED);
assign start_cmd = cr_wr & wdata_r[`CPS_B_RUN] & ~wdata_r[`CPS_B_HALT];
// Abort with count left; feeds the pin at once so it cannot dip for a cycle
assign prq_set = cr_wr & wr_rdma[2] & port_request_out & ~rdma_count_zero;

// Strobe edges; address and data pins are held by the host while a
// strobe is asserted, so they are taken raw on the synchronised edge
always @(posedge clk) begin
   if (rst) begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
      read_ack_in_d_r <= 1'b0;
      write_ack_in_d_r <= 1'b0;
      acc_rd_r <= 1'b0;
      acc_wr_r <= 1'b0;
      addr_r <= 4'h0;
      wdata_r <= 8'h00;
   end else begin
      rd_d_r <= rd_s;
      wr_d_r <= wr_s;
      read_ack_in_d_r <= read_ack_in_s;
      write_ack_in_d_r <= write_ack_in_s;
      acc_rd_r <= rd_s & ~rd_d_r;
      acc_wr_r <= wr_s & ~wr_d_r;
      if ((rd_s & ~rd_d_r) | (wr_s & ~wr_d_r)) begin
         addr_r <= reg_addr_lines;
         wdata_r <= data_in;
      end
   end
end

// Read data and drive enable; data drives while the read strobe is high
always @(posedge clk) begin
   if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      ext_page <= `CPS_RST_PAGE;
      ext_addr <= 4'h0;
      ext_wr_data <= 8'h00;
   end else begin
      ext_page <= page_r;
      ext_addr <= addr_r;
      ext_wr_data <= wdata_r;
      if (acc_rd_r) begin
         data_out <= dec_rd_data;
         data_oe <= 1'b1;
      end else if (!rd_s) begin
         data_oe <= 1'b0;
      end
   end
end

// Run state: stop waits for frames in flight to finish
always @* begin
   run_state_nxt = run_state_r;
   case (run_state_r)
      ST_STOPPED: begin
         if (run_r && !halt_r) begin
            run_state_nxt = ST_RUN;
         end
      end
      ST_RUN: begin
         if (halt_r) begin
            run_state_nxt = busy ? ST_DRAIN : ST_STOPPED;
         end
      end
      ST_DRAIN: begin
         if (!busy) begin
            run_state_nxt = ST_STOPPED;
         end
      end
      default: run_state_nxt = ST_STOPPED;
   endcase
end

always @(posedge clk) begin
   if (rst) begin
      run_state_r <= ST_STOPPED;
      controller_online <= 1'b0;
      int_status_rst <= `CPS_RST_STATUS;
   end else begin
      run_state_r <= run_state_nxt;
      controller_online <= (run_state_nxt == ST_RUN);
      // Entry into reset wins over a start written in the same cycle
      if (enter_stop) begin
         int_status_rst <= 1'b1;
      end else if (start_cmd) begin
         int_status_rst <= 1'b0;
      end
   end
end

// Page, halt, run and send-frame bits
always @(posedge clk) begin
   if (rst) begin
      page_r <= `CPS_RST_PAGE;
      halt_r <= `CPS_RST_HALT;
      run_r <= `CPS_RST_RUN;
      go_r <= 1'b0;
      tx_go_pulse <= 1'b0;
   end else begin
      tx_go_pulse <= 1'b0;
      if (tx_done || tx_abort) begin
         go_r <= 1'b0;
      end
      if (fault_stop) begin
         halt_r <= 1'b1;
      end
      if (cr_wr) begin
         page_r <= wdata_r[`CPS_B_PAGE_HI:`CPS_B_PAGE_LO];
         halt_r <= wdata_r[`CPS_B_HALT] | fault_stop;
         // Run stays set when halt arrives on a started controller
         run_r <= wdata_r[`CPS_B_RUN] | (wdata_r[`CPS_B_HALT] & run_r);
         // A zero leaves the bit alone; a one wins over a same-cycle done
         if (wdata_r[`CPS_B_GO]) begin
            go_r <= 1'b1;
            tx_go_pulse <= 1'b1;
         end
      end
   end
end

// Remote DMA command decode and port request hold
always @(posedge clk) begin
   if (rst) begin
      rdma_cmd_r <= `CPS_RST_RDMA;
      rdma_active_r <= 1'b0;
      reload_r <= 1'b0;
      prq_hold_r <= 1'b0;
      port_request_out <= 1'b0;
      rdma_start_pulse <= 1'b0;
      rdma_abort_pulse <= 1'b0;
      rdma_done_now <= 1'b0;
   end else begin
      rdma_start_pulse <= 1'b0;
      rdma_abort_pulse <= 1'b0;
      rdma_done_now <= 1'b0;
      port_request_out <= rdma_prq_req | prq_hold_r | prq_set;
      if (ack_rise) begin
         prq_hold_r <= 1'b0;
      end
      if (rdma_finished) begin
         rdma_active_r <= 1'b0;
         rdma_cmd_r <= `CPS_RDMA_ABORT;
      end
      if (cr_wr) begin
         if (wr_rdma[2]) begin
            // Abort only stops the engine; start addresses keep their
            // advanced values, so no restore path exists here
            rdma_cmd_r <= wr_rdma;
            rdma_active_r <= 1'b0;
            rdma_abort_pulse <= rdma_active_r;
            if (port_request_out && !rdma_count_zero) begin
               prq_hold_r <= 1'b1;
            end
         end else if (wr_rdma != `CPS_RDMA_NONE) begin
            if (rdma_active_r && (wr_rdma == rdma_cmd_r) && !reload_r) begin
               // Same command again with no new count ends the transfer
               rdma_done_now <= 1'b1;
               rdma_active_r <= 1'b0;
               rdma_cmd_r <= `CPS_RDMA_ABORT;
            end else if (!rdma_active_r || (wr_rdma == rdma_cmd_r)) begin
               rdma_cmd_r <= wr_rdma;
               rdma_active_r <= 1'b1;
               rdma_start_pulse <= 1'b1;
               reload_r <= 1'b0;
            end
         end
      end
      // A count reload wins over the clear at a command start
      if (ext_wr_pulse && (page_r == `CPS_PAGE0) &&
          ((addr_r == `CPS_A_RCNT_LO) || (addr_r == `CPS_A_RCNT_HI))) begin
         reload_r <= 1'b1;
      end
   end
end

endmodule
`default_nettype wire

// ### testbench/cpsreg_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cpsreg_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host pins
   input wire logic rd_strobe,
   input wire logic data_oe,
   input wire logic read_ack_in,
   input wire logic port_request_out,
   // Outside bank
   input wire logic ext_wr_pulse,
   input wire logic [1:0] ext_page,
   input wire logic [3:0] ext_addr,
   // Controller and engines
   input wire logic controller_online,
   input wire logic int_status_rst,
   input wire logic rx_busy,
   input wire logic tx_busy,
   input wire logic tx_go_pulse,
   input wire logic rdma_start_pulse,
   input wire logic rdma_done_now,
   input wire logic [2:0] rdma_cmd,
   input wire logic rdma_prq_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_late; $rose(data_oe) |-> $past(rd_strobe, 4); endproperty
   a_rd_late: assert property (p_rd_late) else $error("read answer without strobe");
   property p_ext_wr; ext_wr_pulse |=> ext_page != 2'h3
      && !(ext_page == 2'h2 && (ext_addr == 4'h4 || ext_addr[3])); endproperty
   a_ext_wr: assert property (p_ext_wr) else $error("reserved write passed on");
   property p_go_pulse; tx_go_pulse |=> !tx_go_pulse; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("transmit start too long");
   property p_drain; $rose(int_status_rst) |-> !$past(rx_busy) && !$past(tx_busy); endproperty
   a_drain: assert property (p_drain) else $error("stopped with frame in flight");
   property p_online; $rose(controller_online) |-> !int_status_rst; endproperty
   a_online: assert property (p_online) else $error("online with reset status");
   property p_start; $fell(int_status_rst) |-> ##[0:2] controller_online; endproperty
   a_start: assert property (p_start) else $error("start did not activate");
   property p_prq_follow; rdma_prq_req |=> port_request_out; endproperty
   a_prq_follow: assert property (p_prq_follow) else $error("port request lost");
   property p_prq_quiet; !rdma_prq_req && !port_request_out |=> !port_request_out; endproperty
   a_prq_quiet: assert property (p_prq_quiet) else $error("port request from nothing");
   property p_rd_cmd; rdma_start_pulse |-> rdma_cmd != 3'h0 && !rdma_cmd[2]; endproperty
   a_rd_cmd: assert property (p_rd_cmd) else $error("remote start with bad code");
   property p_done; rdma_done_now |-> ##[0:1] rdma_cmd == 3'h4; endproperty
   a_done: assert property (p_done) else $error("immediate completion kept code");
endmodule
bind cpsreg_top cpsreg_chk chk (.clk, .rst, .rd_strobe, .data_oe, .read_ack_in,
   .port_request_out, .ext_wr_pulse, .ext_page, .ext_addr, .controller_online,
   .int_status_rst, .rx_busy, .tx_busy, .tx_go_pulse, .rdma_start_pulse, .rdma_done_now,
   .rdma_cmd, .rdma_prq_req);
`default_nettype wire

// ### testbench/cpsreg_host.sv
`timescale 1ns/1ns
`default_nettype none
module cpsreg_host (
   // Clock
   input wire logic clk,
   // Pins the host drives
   output logic [3:0] reg_addr_lines,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic [7:0] data_in,
   output logic read_ack_in,
   output logic write_ack_in,
   // Read answer
   input wire logic [7:0] data_out,
   input wire logic data_oe
);
   // Idle pins at time zero
   initial begin
      reg_addr_lines = 4'h0;
      rd_strobe = 1'b0;
      wr_strobe = 1'b0;
      data_in = 8'h00;
      read_ack_in = 1'b0;
      write_ack_in = 1'b0;
   end
   // Strobe held past the pin filter, long gap after
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr_lines <= a;
      data_in <= d;
      wr_strobe <= 1'b1;
      repeat (6) @(posedge clk);
      wr_strobe <= 1'b0;
      @(posedge clk);
      data_in <= ~d; // Released bus must not show stale data
      repeat (6) @(posedge clk);
   endtask
   // Strobe stays up until the answer is driven
   task rd(input logic [3:0] a, output logic [7:0] q);
      int n;
      @(posedge clk);
      reg_addr_lines <= a;
      rd_strobe <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (data_oe !== 1'b1 && n < 20);
      q = data_out;
      @(posedge clk);
      rd_strobe <= 1'b0;
      for (n = 0; n < 20 && data_oe !== 1'b0; n++) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask
   // One acknowledge pulse, read or write
   task ack(input logic w);
      @(posedge clk);
      read_ack_in <= !w;
      write_ack_in <= w;
      repeat (6) @(posedge clk);
      read_ack_in <= 1'b0;
      write_ack_in <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ### testbench/command_and_page_select_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module command_and_page_select_regs_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rx_busy = 1'b0, tx_busy = 1'b0, fault_stop = 1'b0, tx_done = 1'b0, tx_abort = 1'b0;
   logic rdma_finished = 1'b0, rdma_count_zero = 1'b0, rdma_prq_req = 1'b0;
   logic [7:0] base = 8'h00, q, e;
   logic [15:0] r;
   wire [3:0] reg_addr_lines, ext_addr;
   wire [1:0] ext_page;
   wire [2:0] rdma_cmd;
   wire rd_strobe, wr_strobe, read_ack_in, write_ack_in, data_oe, port_request_out;
   wire ext_wr_pulse, ext_rd_pulse, controller_online, int_status_rst, tx_go_pulse;
   wire rdma_start_pulse, rdma_abort_pulse, rdma_done_now;
   wire [7:0] data_in, data_out, ext_wr_data, ext_rd_data;
   int error_cnt = 0, checks_done = 0, cyc = 0, i, n, go_n = 0, st_n = 0, ab_n = 0, dn_n = 0;
   int ew_n = 0, er_n = 0;
   // Cr value, address, kind: 0 copy, 1 zero, 2 outside, 3 command; no row enters page 3
   logic [15:0] rows [0:12] = '{16'ha110, 16'ha120, 16'ha140, 16'ha1c0, 16'ha1d0, 16'ha1e0,
      16'ha1f0, 16'ha191, 16'ha132, 16'ha103, 16'h6132, 16'h6103, 16'h2172};
   // Copies differ per address so a wrong mux shows
   wire [7:0] ring_start_page = base ^ 8'h01, ring_stop_page = base ^ 8'h02;
   wire [7:0] tx_start_page = base ^ 8'h04, rx_config = base ^ 8'h0c, tx_config = base ^ 8'h0d;
   wire [7:0] data_config = base ^ 8'h0e, int_mask = base ^ 8'h0f;
   assign ext_rd_data = {4'h5, reg_addr_lines};
   cpsreg_host host (.clk, .reg_addr_lines, .rd_strobe, .wr_strobe, .data_in, .read_ack_in,
      .write_ack_in, .data_out, .data_oe);
   cpsreg_top dut (.clk, .rst, .reg_addr_lines, .rd_strobe, .wr_strobe, .data_in, .data_out,
      .data_oe, .read_ack_in, .write_ack_in, .port_request_out, .ext_wr_pulse, .ext_rd_pulse,
      .ext_page, .ext_addr, .ext_wr_data, .ext_rd_data, .ring_start_page, .ring_stop_page,
      .tx_start_page, .rx_config, .tx_config, .data_config, .int_mask, .rx_busy, .tx_busy,
      .fault_stop, .controller_online, .int_status_rst, .tx_go_pulse, .tx_done, .tx_abort,
      .rdma_start_pulse, .rdma_abort_pulse, .rdma_done_now, .rdma_cmd, .rdma_finished,
      .rdma_count_zero, .rdma_prq_req);
   always #20 clk = ~clk;
   // Pulse counts and hang guard
   always @(posedge clk) begin
      go_n += (tx_go_pulse === 1'b1);
      st_n += (rdma_start_pulse === 1'b1);
      ab_n += (rdma_abort_pulse === 1'b1);
      dn_n += (rdma_done_now === 1'b1);
      ew_n += (ext_wr_pulse === 1'b1);
      er_n += (ext_rd_pulse === 1'b1);
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task chk(input string nm, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      host.rd(4'h0, q);
      chk("cmd", 8'h21, q);
      chk("status", 8'h01, {7'h0, int_status_rst});
      $display("test reset done");
      for (i = 0; i < 13; i++) begin
         r = rows[i];
         @(posedge clk);
         base <= 8'h3c + {i[3:0], 4'h0};
         host.wr(4'h0, r[15:8]);
         host.rd(r[7:4], q);
         e = r[3:0] == 4'h0 ? base ^ {4'h0, r[7:4]} : r[3:0] == 4'h1 ? 8'h00 :
            r[3:0] == 4'h2 ? {4'h5, r[7:4]} : r[15:8];
         chk("row", e, q);
      end
      chk("ext_reads", 8'h03, er_n[7:0]);
      host.wr(4'h0, 8'ha1);
      n = ew_n;
      host.wr(4'h4, 8'h99);
      chk("ext_writes", n[7:0], ew_n[7:0]);
      host.wr(4'h0, 8'h22);
      chk("online", 8'h01, {7'h0, controller_online});
      chk("status", 8'h00, {7'h0, int_status_rst});
      $display("test table and start done");
      @(posedge clk);
      rx_busy <= 1'b1;
      tx_busy <= 1'b1;
      host.wr(4'h0, 8'h21);
      host.rd(4'h0, q);
      chk("cmd", 8'h23, q);
      @(posedge clk);
      tx_busy <= 1'b0;
      repeat (6) @(posedge clk);
      chk("status", 8'h00, {7'h0, int_status_rst});
      rx_busy <= 1'b0;
      for (n = 0; n < 10 && int_status_rst !== 1'b1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk("status", 8'h01, {7'h0, int_status_rst});
      chk("online", 8'h00, {7'h0, controller_online});
      $display("test stop done");
      host.wr(4'h0, 8'h22);
      host.wr(4'h0, 8'h26);
      host.wr(4'h0, 8'h22);
      host.rd(4'h0, q);
      chk("cmd", 8'h26, q);
      chk("go_pulses", 8'h01, go_n[7:0]);
      @(posedge clk);
      tx_done <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
      host.rd(4'h0, q);
      chk("cmd", 8'h22, q);
      $display("test transmit done");
      host.wr(4'h0, 8'h0a);
      chk("rdma_cmd", 8'h01, {5'h0, rdma_cmd});
      @(posedge clk);
      rdma_prq_req <= 1'b1;
      host.wr(4'h0, 8'h22);
      chk("aborts", 8'h01, ab_n[7:0]);
      rdma_prq_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk("prq", 8'h01, {7'h0, port_request_out});
      host.ack(1'b0);
      chk("prq", 8'h00, {7'h0, port_request_out});
      host.wr(4'ha, 8'h00);
      host.wr(4'hb, 8'h00);
      host.wr(4'ha, 8'h10);
      chk("ext_wr_data", 8'h10, ext_wr_data);
      chk("ext_addr", 8'h0a, {2'h0, ext_page, ext_addr});
      host.wr(4'h8, 8'h00);
      host.wr(4'h0, 8'h12);
      chk("rdma_cmd", 8'h02, {5'h0, rdma_cmd});
      host.wr(4'h0, 8'h16);
      chk("done_now", 8'h01, dn_n[7:0]);
      chk("rdma_cmd", 8'h04, {5'h0, rdma_cmd});
      host.wr(4'h0, 8'h02);
      chk("rdma_cmd", 8'h04, {5'h0, rdma_cmd});
      host.wr(4'h0, 8'h1a);
      chk("starts", 8'h03, st_n[7:0]);
      rdma_finished <= 1'b1;
      @(posedge clk);
      rdma_finished <= 1'b0;
      repeat (2) @(posedge clk);
      chk("rdma_cmd", 8'h04, {5'h0, rdma_cmd});
      $display("test remote done");
      fault_stop <= 1'b1;
      @(posedge clk);
      fault_stop <= 1'b0;
      for (n = 0; n < 10 && int_status_rst !== 1'b1; n++) @(posedge clk);
      repeat (2) @(posedge clk);
      chk("status", 8'h01, {7'h0, int_status_rst});
      host.wr(4'h0, 8'h22);
      chk("online", 8'h01, {7'h0, controller_online});
      $display("test error stop done");
      give_verdict();
   end
endmodule
`default_nettype wire
